// ===== hdl/async_mux_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes byte addressing over a 16-bit host bus with two byte lanes
`ifndef ASYNC_MUX_REGS_SVH
`define ASYNC_MUX_REGS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define OFS_CONTROL_STATUS  3'h0
`define OFS_RX_BUF_LINE_PAR 3'h2
`define OFS_TX_EN_DTR       3'h4
`define OFS_TX_BUF_BRK      3'h6

// ************************************************************
// control_status_reg fields
// ************************************************************
`define CSR_MAINT     3
`define CSR_CLEAR     4
`define CSR_MSE       5
`define CSR_RIE       6
`define CSR_RX_CHAR_AVAILABLE     7
`define CSR_TX_LINE_NUMBER_LO  8
`define CSR_TX_LINE_NUMBER_HI  10
`define CSR_SAE       12
`define CSR_SA        13
`define CSR_TIE       14
`define CSR_TX_READY_FLAG      15

// ************************************************************
// line_parameter_reg fields
// ************************************************************
`define LPR_LINE_HI   2
`define LPR_LEN_LO    3
`define LPR_LEN_HI    4
`define LPR_STOP2     5
`define LPR_PAR_EN    6
`define LPR_PAR_ODD   7
`define LPR_SPEED_LO  8
`define LPR_SPEED_HI  11
`define LPR_RX_EN     12
`define LINE_CFG_W    10

// ************************************************************
// receive_buffer fields, reset values and counts
// ************************************************************
`define RECEIVE_BUFFER_VALID    15
`define ALARM_COUNT   5'h10
`define CFG_RESET     10'h000
`define BIT_BASE_CYC  16

`endif

// ===== hdl/async_mux_pkg.sv
// types shared by the multiplexer design files
// assumes the constants header supplies all numeric values
package async_mux_pkg;
  typedef logic [2:0] line_t;
  typedef enum logic [0:0] {
    SCAN_SEARCH = 1'b0,
    SCAN_HOLD   = 1'b1
  } scan_state_e;
endpackage : async_mux_pkg

// ===== hdl/rx_silo_fifo.sv
// first-in first-out buffer with valid/ready on both sides
// assumes a single clock; flush empties it in one cycle
`timescale 1ns/10ps
`default_nettype none
module rx_silo_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else if (flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : rx_silo_fifo
`default_nettype wire

// ===== hdl/async_mux.sv
// eight-line asynchronous multiplexer: host registers, receive silo with
// alarm, transmit scanner, per-line double-buffered transmitters, break
// assumes assembled receive characters arrive on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "async_mux_regs.svh"
module async_mux #(
  parameter int LINES      = 8,
  parameter int SILO_DEPTH = 64,
  parameter int BIT_BASE   = `BIT_BASE_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [2:0]  busAddr,
  input  wire logic [1:0]  busByteEn,
  input  wire logic        busWrite,
  input  wire logic        busRead,
  input  wire logic [15:0] busWdata,
  output logic      [15:0] busRdata,
  input  wire logic        rxCharValid,
  output logic             rxCharReady,
  input  wire logic [2:0]  rxCharLine,
  input  wire logic [7:0]  rxCharData,
  input  wire logic [2:0]  rxCharStatus,
  input  wire logic [7:0]  carrierIn,
  input  wire logic [7:0]  ringIn,
  output logic      [7:0]  txData,
  output logic      [7:0]  dtrOut,
  output logic             rxIrq,
  output logic             txIrq
);
  // ************************************************************
  // bus decode
  // ************************************************************
  logic        selCsr;
  logic        selRbuf;
  logic        selTxEn;
  logic        selTxBuf;
  logic        clrPulse;
  logic        rbufAccess;
  logic        tbufWr;

  assign selCsr     = (busAddr[2:1] == 2'(`OFS_CONTROL_STATUS  >> 1));
  assign selRbuf    = (busAddr[2:1] == 2'(`OFS_RX_BUF_LINE_PAR >> 1));
  assign selTxEn    = (busAddr[2:1] == 2'(`OFS_TX_EN_DTR       >> 1));
  assign selTxBuf   = (busAddr[2:1] == 2'(`OFS_TX_BUF_BRK      >> 1));
  assign clrPulse   = busWrite & selCsr & busByteEn[0] & busWdata[`CSR_CLEAR];
  assign rbufAccess = busRead & selRbuf;

  // ************************************************************
  // control_status_reg
  // ************************************************************
  logic                      maint_q;
  logic                      mse_q;
  logic                      rie_q;
  logic                      sae_q;
  logic                      tie_q;
  logic                      saFlag_q;
  logic [4:0]                saCnt_q;
  async_mux_pkg::scan_state_e scan_q;
  async_mux_pkg::line_t       tx_line_number_q;
  logic                      tx_ready_flag;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      maint_q <= 1'b0;
      mse_q   <= 1'b0;
      rie_q   <= 1'b0;
      sae_q   <= 1'b0;
      tie_q   <= 1'b0;
    end else if (busWrite && selCsr) begin
      if (busByteEn[0]) begin
        // clear drops scanning too, like initialisation
        maint_q <= busWdata[`CSR_MAINT] & ~busWdata[`CSR_CLEAR];
        mse_q   <= busWdata[`CSR_MSE] & ~busWdata[`CSR_CLEAR];
        rie_q   <= busWdata[`CSR_RIE] & ~busWdata[`CSR_CLEAR];
      end
      if (busByteEn[1]) begin
        sae_q <= busWdata[`CSR_SAE];
        tie_q <= busWdata[`CSR_TIE];
      end
    end
  end

  // ************************************************************
  // receive silo and alarm
  // ************************************************************
  logic [`LINE_CFG_W-1:0] lineCfg_q [LINES];
  logic                   rxLineOn;
  logic                   siloInValid;
  logic                   siloInReady;
  logic                   siloOutValid;
  logic [14:0]            siloOut;
  logic                   push;

  assign rxLineOn    = mse_q & lineCfg_q[rxCharLine][`LPR_RX_EN-3];
  assign siloInValid = rxCharValid & rxLineOn;
  // chars for a disabled line are consumed and dropped
  assign rxCharReady = siloInReady | ~rxLineOn;
  assign push        = siloInValid & siloInReady;

  rx_silo_fifo #(
    .WIDTH (15),
    .DEPTH (SILO_DEPTH)
  ) rx_silo_fifo_i (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .flush    (clrPulse),
    .inValid  (siloInValid),
    .inReady  (siloInReady),
    .inData   ({rxCharStatus, 1'b0, rxCharLine, rxCharData}),
    .outValid (siloOutValid),
    .outReady (rbufAccess),
    .outData  (siloOut)
  );

  // an arrival in the access cycle still counts as one, so none is lost
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      saCnt_q  <= '0;
      saFlag_q <= 1'b0;
    end else if (clrPulse) begin
      saCnt_q  <= '0;
      saFlag_q <= 1'b0;
    end else if (rbufAccess) begin
      saCnt_q  <= {4'h0, push};
      saFlag_q <= 1'b0;
    end else if (push && saCnt_q != `ALARM_COUNT) begin
      saCnt_q  <= saCnt_q + 5'h01;
      saFlag_q <= (saCnt_q + 5'h01 == `ALARM_COUNT) | saFlag_q;
    end
  end

  // level request: with the alarm off, reasserts as long as chars remain at the bottom
  assign rxIrq = rie_q & (sae_q ? saFlag_q : siloOutValid);
  assign txIrq = tie_q & tx_ready_flag;

  // ************************************************************
  // line parameters, tx enable, terminal ready, break
  // ************************************************************
  logic [7:0] txEn_q;
  logic [7:0] brk_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < LINES; i++) begin
        lineCfg_q[i] <= `CFG_RESET;
      end
    end else if (clrPulse) begin
      for (int i = 0; i < LINES; i++) begin
        lineCfg_q[i] <= `CFG_RESET;
      end
    end else if (busWrite && selRbuf && busByteEn == 2'b11) begin
      lineCfg_q[busWdata[`LPR_LINE_HI:0]] <= busWdata[`LPR_RX_EN:`LPR_LEN_LO];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txEn_q <= 8'h00;
      dtrOut <= 8'h00;
    end else begin
      if (clrPulse) begin
        txEn_q <= 8'h00;
      end else if (busWrite && selTxEn && busByteEn[0]) begin
        txEn_q <= busWdata[7:0];
      end
      // terminal ready survives a clear, only reset drops it
      if (busWrite && selTxEn && busByteEn[1]) begin
        dtrOut <= busWdata[15:8];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      brk_q <= 8'h00;
    end else if (clrPulse) begin
      brk_q <= 8'h00;
    end else if (busWrite && selTxBuf && busByteEn[1]) begin
      brk_q <= busWdata[15:8];
    end
  end

  // ************************************************************
  // modem inputs: three flops, change taken when last two agree
  // ************************************************************
  logic [15:0] mdm1_q;
  logic [15:0] mdm2_q;
  logic [15:0] mdm3_q;
  logic [15:0] mdm_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mdm1_q <= 16'h0000;
      mdm2_q <= 16'h0000;
      mdm3_q <= 16'h0000;
      mdm_q  <= 16'h0000;
    end else begin
      mdm1_q <= {carrierIn, ringIn};
      mdm2_q <= mdm1_q;
      mdm3_q <= mdm2_q;
      mdm_q  <= (mdm3_q & ~(mdm2_q ^ mdm3_q)) | (mdm_q & (mdm2_q ^ mdm3_q));
    end
  end

  // ************************************************************
  // transmit scanner
  // ************************************************************
  logic [7:0]           holdFull_q;
  logic [7:0]           need;
  async_mux_pkg::line_t found;

  assign tx_ready_flag   = (scan_q == async_mux_pkg::SCAN_HOLD);
  assign tbufWr = busWrite & selTxBuf & busByteEn[0] & tx_ready_flag;
  assign need   = txEn_q & ~holdFull_q;

  always_comb begin
    found = '0;
    // ascending walk so the highest line wins
    for (int i = 0; i < LINES; i++) begin
      if (need[i]) begin
        found = async_mux_pkg::line_t'(i);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scan_q  <= async_mux_pkg::SCAN_SEARCH;
      tx_line_number_q <= '0;
    end else if (clrPulse) begin
      scan_q  <= async_mux_pkg::SCAN_SEARCH;
    end else begin
      case (scan_q)
        async_mux_pkg::SCAN_SEARCH: begin
          if (mse_q && need != 8'h00) begin
            tx_line_number_q <= found;
            scan_q  <= async_mux_pkg::SCAN_HOLD;
          end
        end
        async_mux_pkg::SCAN_HOLD: begin
          // line number frozen until serviced or disabled
          if (tbufWr || !txEn_q[tx_line_number_q]) begin
            scan_q <= async_mux_pkg::SCAN_SEARCH;
          end
        end
        default: scan_q <= async_mux_pkg::SCAN_SEARCH;
      endcase
    end
  end

  // ************************************************************
  // per-line double-buffered transmitters
  // ************************************************************
  function automatic logic [15:0] build_frame(input logic [7:0] d, input logic [6:0] cfg);
    logic [11:0] f;
    logic [3:0]  n;
    logic [7:0]  m;
    f = 12'hfff;
    n = 4'h5 + {2'b00, cfg[1:0]};
    m = d & ~(8'hff << n);
    f[0] = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (k < n) begin
        f[k+1] = m[k];
      end
    end
    if (cfg[`LPR_PAR_EN-3]) begin
      f[n+1] = (^m) ^ cfg[`LPR_PAR_ODD-3];
    end
    return {f, n + 4'h2 + {3'b000, cfg[`LPR_PAR_EN-3]} + {3'b000, cfg[`LPR_STOP2-3]}};
  endfunction : build_frame

  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi++) begin : g_tx
      logic [7:0]  hold_q;
      logic [11:0] shift_q;
      logic [3:0]  bits_q;
      logic [15:0] baud_q;
      logic        active_q;
      logic [15:0] bitCyc;
      logic [15:0] frame;

      assign bitCyc = 16'(BIT_BASE * (lineCfg_q[gi][`LPR_SPEED_HI-3:`LPR_SPEED_LO-3] + 1));
      assign frame  = build_frame(hold_q, lineCfg_q[gi][6:0]);

      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          holdFull_q[gi] <= 1'b0;
          hold_q         <= 8'h00;
        end else if (clrPulse) begin
          holdFull_q[gi] <= 1'b0;
        end else if (tbufWr && tx_line_number_q == async_mux_pkg::line_t'(gi)) begin
          holdFull_q[gi] <= 1'b1;
          hold_q         <= busWdata[7:0];
        end else if (!active_q && mse_q) begin
          holdFull_q[gi] <= 1'b0;
        end
      end

      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          active_q <= 1'b0;
          shift_q  <= 12'hfff;
          bits_q   <= 4'h0;
          baud_q   <= 16'h0000;
        end else if (clrPulse) begin
          active_q <= 1'b0;
          shift_q  <= 12'hfff;
        end else if (!active_q) begin
          if (holdFull_q[gi] && mse_q) begin
            active_q <= 1'b1;
            shift_q  <= frame[15:4];
            bits_q   <= frame[3:0];
            baud_q   <= bitCyc - 16'h0001;
          end
        end else if (baud_q != 16'h0000) begin
          baud_q <= baud_q - 16'h0001;
        end else if (bits_q == 4'h1) begin
          active_q <= 1'b0;
          shift_q  <= 12'hfff;
        end else begin
          shift_q <= {1'b1, shift_q[11:1]};
          bits_q  <= bits_q - 4'h1;
          baud_q  <= bitCyc - 16'h0001;
        end
      end

      // break overrides the shifter, which keeps running underneath
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          txData[gi] <= 1'b1;
        end else begin
          txData[gi] <= ~brk_q[gi] & (~active_q | shift_q[0]);
        end
      end
    end
  endgenerate

  // ************************************************************
  // read data
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busRdata <= 16'h0000;
    end else if (busRead) begin
      case (busAddr[2:1])
        2'h0: busRdata <= {tx_ready_flag, tie_q, saFlag_q, sae_q, 1'b0, tx_line_number_q,
                           siloOutValid, rie_q, mse_q, 1'b0, maint_q, 3'h0};
        2'h1: busRdata <= {siloOutValid, siloOut};
        2'h2: busRdata <= {dtrOut, txEn_q};
        2'h3: busRdata <= mdm_q;
        default: busRdata <= 16'h0000;
      endcase
    end
  end
endmodule : async_mux
`default_nettype wire

// ===== bench/async_mux_monitor.sv
// concurrent checks on the multiplexer host and line ports
// assumes it is bound to async_mux; one clock domain
`timescale 1ns/10ps
`default_nettype none
module async_mux_monitor (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [2:0]  busAddr,
  input wire logic [1:0]  busByteEn,
  input wire logic        busWrite,
  input wire logic        busRead,
  input wire logic [15:0] busWdata,
  input wire logic [15:0] busRdata,
  input wire logic [7:0]  txData,
  input wire logic [7:0]  dtrOut,
  input wire logic        rxIrq,
  input wire logic        txIrq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic quiet_q;
  logic sae_q;
  wire  csrWr  = busWrite && busAddr[2:1] == 2'h0;
  wire  brkWr  = busWrite && busAddr[2:1] == 2'h3 && busByteEn[1];
  wire  tbufWr = busWrite && busAddr[2:1] == 2'h3 && busByteEn[0];
  wire  rbufRd = busRead && busAddr[2:1] == 2'h1;
  // ****
  // helper state
  // ****
  // no line may leave marking before the first transmit or break write to any line
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      quiet_q <= 1'b1;
    else if (busWrite && busAddr[2:1] == 2'h3)
      quiet_q <= 1'b0;
  end
  // clear does not touch the alarm enable, so only writes move it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      sae_q <= 1'b0;
    else if (csrWr && busByteEn[1])
      sae_q <= busWdata[12];
  end
  // ****
  // assertions
  // ****
  AST_IDLE_MARK: assert property (quiet_q |-> txData == 8'hff)
    else $error("idle line not marking");
  AST_RX_MASK: assert property (csrWr && busByteEn[0] && !busWdata[6] |=> !rxIrq)
    else $error("rx request while masked");
  AST_RX_ALARM: assert property (sae_q && rbufRd |=> !rxIrq)
    else $error("rx request after buffer access in alarm mode");
  AST_TX_MASK: assert property (csrWr && busByteEn[1] && !busWdata[14] |=> !txIrq)
    else $error("tx request while masked");
  AST_TX_SERVED: assert property (tbufWr |=> !txIrq)
    else $error("tx ready kept after char write");
  AST_TX_HOLD: assert property (txIrq && !busWrite && !$past(busWrite) |=> txIrq)
    else $error("tx ready dropped unserviced");
  AST_DTR_WORD: assert property (busWrite && busAddr[2:1] == 2'h2 && busByteEn[1]
    |=> dtrOut == $past(busWdata[15:8]))
    else $error("terminal ready not written");
  AST_BREAK_SPACE: assert property (brkWr |-> ##2
    (txData & $past(busWdata[15:8], 2)) == 8'h00)
    else $error("break line not spacing");
  sequence csrRdS;
    busRead && busAddr[2:1] == 2'h0;
  endsequence
  AST_ALARM_CLEAR: assert property (rbufRd ##2 csrRdS |=> !busRdata[13])
    else $error("alarm flag survived buffer access");
  COV_TX: cover property (txIrq && !busWrite);
  COV_ALARM: cover property (sae_q && $rose(rxIrq));
  COV_BREAK: cover property (brkWr && busWdata[15:8] != 8'h00);
endmodule : async_mux_monitor
bind async_mux async_mux_monitor async_mux_monitor_i (.clk(clk), .sys_rst(sys_rst),
  .busAddr(busAddr), .busByteEn(busByteEn), .busWrite(busWrite), .busRead(busRead),
  .busWdata(busWdata), .busRdata(busRdata), .txData(txData), .dtrOut(dtrOut),
  .rxIrq(rxIrq), .txIrq(txIrq));
`default_nettype wire

// ===== bench/rx_char_source.sv
// receiver-side model offering assembled characters to the silo
// assumes one caller at a time
`timescale 1ns/10ps
`default_nettype none
module rx_char_source (
  input  wire logic       clk,
  output logic            rxCharValid,
  input  wire logic       rxCharReady,
  output logic      [2:0] rxCharLine,
  output logic      [7:0] rxCharData,
  output logic      [2:0] rxCharStatus
);
  // ****
  // offer and hold
  // ****
  initial begin
    rxCharValid  = 1'b0;
    rxCharLine   = 3'h0;
    rxCharData   = 8'h00;
    rxCharStatus = 3'h0;
  end
  // released fields flip so a stale value never passes for a new one
  task automatic send(input logic [2:0] l, input logic [7:0] d, input logic [2:0] s,
                      input int gap);
    int t;
    t = 0;
    repeat (gap + 1) @(posedge clk);
    rxCharValid  <= 1'b1;
    rxCharLine   <= l;
    rxCharData   <= d;
    rxCharStatus <= s;
    do begin
      @(posedge clk);
      t++;
    end while (rxCharReady !== 1'b1 && t < 50);
    rxCharValid  <= 1'b0;
    rxCharLine   <= ~l;
    rxCharData   <= ~d;
    rxCharStatus <= ~s;
  endtask : send
endmodule : rx_char_source
`default_nettype wire

// ===== bench/async_mux_bench.sv
// self-checking bench for async_mux with a receiver model on the silo side
// assumes the monitor binds itself; bit time shortened to two cycles
`timescale 1ns/10ps
`default_nettype none
module async_mux_bench;
  localparam int BB = 2;
  logic        clk, sys_rst, busWrite, busRead, rxCharValid, rxCharReady, rxIrq, txIrq;
  logic [1:0]  busByteEn;
  logic [2:0]  busAddr, rxCharLine, rxCharStatus, k;
  logic [7:0]  rxCharData, carrierIn, ringIn, txData, dtrOut, m, d2, gotA, gotB;
  logic [15:0] busWdata, busRdata, rd;
  int          bad_count, tests_run, cyc, n;

  async_mux #(.BIT_BASE(BB)) async_mux_i (.clk(clk), .sys_rst(sys_rst), .busAddr(busAddr),
    .busByteEn(busByteEn), .busWrite(busWrite), .busRead(busRead), .busWdata(busWdata),
    .busRdata(busRdata), .rxCharValid(rxCharValid), .rxCharReady(rxCharReady),
    .rxCharLine(rxCharLine), .rxCharData(rxCharData), .rxCharStatus(rxCharStatus),
    .carrierIn(carrierIn), .ringIn(ringIn), .txData(txData), .dtrOut(dtrOut),
    .rxIrq(rxIrq), .txIrq(txIrq));
  rx_char_source rx_char_source_i (.clk(clk), .rxCharValid(rxCharValid),
    .rxCharReady(rxCharReady), .rxCharLine(rxCharLine), .rxCharData(rxCharData),
    .rxCharStatus(rxCharStatus));
  // ****
  // helpers
  // ****
  task automatic check(input string s, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : check
  // one request per call with a quiet edge between calls
  task automatic bus(input logic w, input logic [2:0] a, input logic [1:0] be,
                     input logic [15:0] d);
    @(posedge clk);
    busWrite  <= w;
    busRead   <= !w;
    busAddr   <= a;
    busByteEn <= be;
    busWdata  <= d;
    @(posedge clk);
    busWrite <= 1'b0;
    busRead  <= 1'b0;
    @(negedge clk);
    rd = busRdata;
  endtask : bus
  task automatic waitHigh(input logic sel);
    int t;
    t = 0;
    while ((sel ? txIrq : rxIrq) !== 1'b1 && t < 80) begin
      @(negedge clk);
      t++;
    end
  endtask : waitHigh
  task automatic expLine(input logic [2:0] l);
    waitHigh(1'b1);
    bus(1'b0, 3'h0, 2'b11, 16'h0);
    check("ready line", {12'h000, 1'b1, l}, {12'h0, rd[15], rd[10:8]});
  endtask : expLine
  function automatic logic [2:0] topLine(input logic [7:0] v);
    topLine = 3'h0;
    for (int i = 0; i < 8; i++)
      if (v[i])
        topLine = 3'(i);
  endfunction : topLine
  // samples half a cycle into each bit on falling edges, eight data bits lsb first
  task automatic decode(input logic [2:0] l, output logic [7:0] d);
    int t;
    t = 0;
    while (txData[l] !== 1'b0 && t < 200) begin
      @(negedge clk);
      t++;
    end
    for (int i = 0; i < 8; i++) begin
      repeat (BB) @(negedge clk);
      d[i] = txData[l];
    end
    repeat (BB) @(negedge clk);
    check("stop bit", 16'h1, {15'h0, txData[l]});
  endtask : decode
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // ****
  // clock, timeout and sequence
  // ****
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("ERROR timeout expected done seen %0d cycles", cyc);
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(94934));
    {sys_rst, busWrite, busRead, busAddr, busByteEn, busWdata} = {3'b100, 21'h0};
    {carrierIn, ringIn, bad_count, tests_run, cyc} = '0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check("reset out", 16'h00ff, {dtrOut, txData});
    bus(1'b0, 3'h4, 2'b11, 16'h0);
    check("enables", 16'h0, rd);
    for (int l = 0; l < 8; l++)
      bus(1'b1, 3'h2, 2'b11, 16'h1018 | 16'(l));
    bus(1'b1, 3'h0, 2'b11, 16'h4060);
    m = 8'($urandom);
    rx_char_source_i.send(3'h5, m, 3'h0, 0);
    rx_char_source_i.send(3'h2, ~m, 3'h4, 3);
    for (int i = 0; i < 2; i++) begin
      waitHigh(1'b0);
      check("rx irq", 16'h1, {15'h0, rxIrq});
      bus(1'b0, 3'h2, 2'b11, 16'h0);
      check("rx buf", {1'b1, i ? 3'h4 : 3'h0, 4'h0, i ? ~m : m}, rd & 16'hf0ff);
    end
    repeat (3) @(negedge clk);
    check("rx idle", 16'h0, {15'h0, rxIrq});
    bus(1'b1, 3'h0, 2'b11, 16'h1060);
    for (int i = 0; i < 16; i++) begin
      check("early alarm", 16'h0, {15'h0, rxIrq});
      rx_char_source_i.send(3'(i), 8'(i), 3'h0, $urandom_range(2));
    end
    waitHigh(1'b0);
    bus(1'b0, 3'h0, 2'b11, 16'h0);
    check("alarm", 16'h3, {14'h0, rxIrq, rd[13]});
    n = 0;
    while (n < 70) begin
      bus(1'b0, 3'h2, 2'b11, 16'h0);
      if (rd[15] !== 1'b1)
        break;
      check("silo order", {8'h01, 8'(n)}, {7'h0, rd[15], rd[7:0]});
      // first access with the alarm request still enabled, then mask
      if (n == 0) begin
        bus(1'b0, 3'h0, 2'b11, 16'h0);
        check("alarm clear", 16'h0, {14'h0, rxIrq, rd[13]});
        bus(1'b1, 3'h0, 2'b11, 16'h1020);
      end
      n++;
    end
    check("drained", 16'd16, 16'(n));
    bus(1'b1, 3'h0, 2'b11, 16'h4020);
    for (int r = 0; r < 4; r++) begin
      m = r == 0 ? 8'hff : 8'($urandom);
      bus(1'b1, 3'h4, 2'b01, {8'h0, m});
      while (m != 8'h0) begin
        expLine(topLine(m));
        m[topLine(m)] = 1'b0;
        bus(1'b1, 3'h4, 2'b01, {8'h0, m});
        repeat (2) @(negedge clk);
      end
      check("no ready", 16'h0, {15'h0, txIrq});
    end
    k = 3'($urandom_range(7));
    m = 8'($urandom);
    d2 = 8'($urandom);
    bus(1'b1, 3'h4, 2'b01, {8'h0, 8'h01 << k});
    expLine(k);
    bus(1'b1, 3'h6, 2'b01, {8'h0, m});
    fork
      decode(k, gotA);
      begin
        repeat (2) @(negedge clk);
        expLine(k);
        bus(1'b1, 3'h6, 2'b01, {8'h0, d2});
      end
    join
    decode(k, gotB);
    check("chars", {m, d2}, {gotA, gotB});
    bus(1'b1, 3'h6, 2'b10, {8'h01 << k, 8'h0});
    repeat (2) @(negedge clk);
    gotA = 8'h0;
    repeat (20) begin
      @(negedge clk);
      gotA = gotA | {7'h0, txData[k]};
    end
    check("break", 16'h0, {8'h0, gotA});
    expLine(k);
    bus(1'b1, 3'h6, 2'b01, 16'h0);
    repeat (2) @(negedge clk);
    expLine(k);
    bus(1'b1, 3'h6, 2'b10, 16'h0);
    repeat (40) @(negedge clk);
    check("mark", 16'h1, {15'h0, txData[k]});
    m = 8'($urandom);
    bus(1'b1, 3'h4, 2'b11, {m, 8'h0});
    bus(1'b0, 3'h4, 2'b11, 16'h0);
    check("dtr word", {m, m}, {dtrOut, rd[15:8]});
    bus(1'b1, 3'h0, 2'b01, 16'h0010);
    bus(1'b0, 3'h4, 2'b11, 16'h0);
    check("clear keeps dtr", {m, 8'h00}, rd);
    @(posedge clk);
    carrierIn <= 8'($urandom);
    ringIn    <= 8'($urandom);
    repeat (8) @(negedge clk);
    bus(1'b0, 3'h6, 2'b11, 16'h0);
    check("modem", {carrierIn, ringIn}, rd);
    tally_and_finish();
  end
endmodule : async_mux_bench
`default_nettype wire
